// ==== src/clock_select_prescale_sleep.sv ====
// Main clock select, prescaler control, oscillator trim and sleep control
`timescale 1ns/10ps
// Notes on behaviour
// RQ1 - Select register upper six bits read zero
// RQ2 - Selector codes: 8M, 128k, external, reserved
// RQ3 - Source switch glitch free at run time
// RQ4 - Selector write needs unlock within four cycles
// RQ5 - Divider register upper four bits read zero
// RQ6 - Division is two to field, 0..8
// RQ7 - Divided clock feeds core and peripherals
// RQ8 - Divider write needs unlock within four cycles
// RQ9 - Divider resets to three, divide by eight
// RQ10 - Software keeps system clock under maximum
// RQ11 - Reset loads factory trim byte
// RQ12 - Trim zero slowest, all ones fastest
// RQ13 - Sleep needs arm bit plus sleep instruction
// RQ14 - Per-mode clock domain and oscillator gating
// RQ15 - Per-mode wake source selection
// RQ16 - Deep modes: level irq zero, address match
// RQ17 - Halt four cycles after start-up, then service
// RQ18 - Sleep leaves register file and memory intact
// RQ19 - Reset in sleep restarts at reset vector
// RQ20 - Level wake source held long enough
// RQ21 - Sleep kind codes 000,001,010,100
// RQ22 - Divider change makes no short period
// RQ23 - Power-down wake waits six oscillator ticks
// RQ24 - Reserved selector or divider writes ignored
// RQ25 - Unlock window closes after four or one write
module clock_select_prescale_sleep (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic osc8m_tick,
    input wire logic osc128k_tick,
    input wire logic ext_clk_tick,
    input wire logic [7:0] factory_trim,
    output logic [7:0] osc_trim,
    output logic [1:0] main_src_active,
    output logic main_tick,
    output logic sys_tick,
    input wire logic sleep_instr,
    input wire logic irq_any,
    input wire logic ext_irq_zero,
    input wire logic ext_irq_zero_level_mode,
    input wire logic pin_change_irq,
    input wire logic watchdog_osc_irq,
    input wire logic two_wire_slave_irq,
    input wire logic two_wire_slave_addr_match,
    input wire logic converter_done_irq,
    output logic core_clk_domain_en,
    output logic nvmem_clk_domain_en,
    output logic periph_clk_domain_en,
    output logic converter_clk_domain_en,
    output logic main_osc_en,
    output logic core_halted,
    output logic irq_service
);
    sys_div_if dif ();
    sys_prescaler u_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .dif(dif)
    );

    logic wr_pend_q;
    logic rd_wait_q;
    logic [7:0] addr_q;
    logic [31:0] hrdata_q;
    logic [1:0] sel_q;
    logic [1:0] src_q;
    logic switching_q;
    logic [3:0] div_q;
    logic [7:0] trim_q;
    logic trim_loaded_q;
    logic win_q;
    logic [2:0] win_cnt_q;
    logic arm_q;
    logic [2:0] kind_q;
    logic [2:0] cur_kind_q;
    logic [2:0] cnt_q;
    clk_ctrl_pkg::sleep_state_type st_q;
    clk_ctrl_pkg::sleep_state_type st_d;

    // Bus decode
    wire addr_take = hsel && hready && (htrans == clk_ctrl_pkg::HTRANS_NONSEQ);
    wire wr_take = addr_take && hwrite;
    wire rd_take = addr_take && !hwrite;
    wire wr_sel = wr_pend_q && (addr_q == clk_ctrl_pkg::OFS_MAIN_SEL);
    wire wr_div = wr_pend_q && (addr_q == clk_ctrl_pkg::OFS_DIV);
    wire wr_trim = wr_pend_q && (addr_q == clk_ctrl_pkg::OFS_TRIM);
    wire wr_key = wr_pend_q && (addr_q == clk_ctrl_pkg::OFS_KEY);
    wire wr_pwr = wr_pend_q && (addr_q == clk_ctrl_pkg::OFS_PWR);
    wire key_ok = wr_key && (hwdata[7:0] == clk_ctrl_pkg::UNLOCK_KEY);
    wire [1:0] wd_src = hwdata[clk_ctrl_pkg::SRC_W-1:0];
    wire [3:0] wd_div = hwdata[clk_ctrl_pkg::DIV_W-1:0];
    wire src_ok = wd_src != clk_ctrl_pkg::SRC_RSVD;
    wire div_ok = wd_div <= clk_ctrl_pkg::DIV_MAX;
    // Reserved codes are dropped but still close the window
    wire prot_wr = win_q && (wr_sel || wr_div);
    wire sel_upd = win_q && wr_sel && src_ok; // RQ4 RQ24
    wire div_upd = win_q && wr_div && div_ok; // RQ8 RQ24
    wire sleeping = st_q != clk_ctrl_pkg::ST_RUN;

    // Read mux, narrow registers sit low with zeros above
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (addr_q)
            clk_ctrl_pkg::OFS_MAIN_SEL: rd_mux[clk_ctrl_pkg::SRC_W-1:0] = sel_q; // RQ1
            clk_ctrl_pkg::OFS_DIV: rd_mux[clk_ctrl_pkg::DIV_W-1:0] = div_q; // RQ5
            clk_ctrl_pkg::OFS_TRIM: rd_mux[7:0] = trim_q;
            clk_ctrl_pkg::OFS_PWR: begin
                rd_mux[clk_ctrl_pkg::PWR_ARM_BIT] = arm_q;
                rd_mux[clk_ctrl_pkg::PWR_KIND_LSB +: clk_ctrl_pkg::KIND_W] = kind_q;
            end
            clk_ctrl_pkg::OFS_STAT: begin
                rd_mux[clk_ctrl_pkg::SRC_W-1:0] = src_q;
                rd_mux[clk_ctrl_pkg::STAT_DIV_LSB +: clk_ctrl_pkg::DIV_W] = dif.div_active;
                rd_mux[clk_ctrl_pkg::STAT_SLEEP_BIT] = sleeping;
                rd_mux[clk_ctrl_pkg::STAT_WIN_BIT] = win_q;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Bus phase tracking; reads take one wait state so data is fresh
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_wait_q <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            wr_pend_q <= wr_take;
            rd_wait_q <= rd_take;
            if (addr_take) begin
                addr_q <= haddr[7:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (rd_wait_q) begin
            hrdata_q <= rd_mux;
        end
    end

    assign hreadyout = !rd_wait_q;
    assign hresp = clk_ctrl_pkg::HRESP_OKAY;
    assign hrdata = hrdata_q;

    // Unlock window, counted in instruction cycles
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            win_q <= 1'b0;
            win_cnt_q <= 3'h0;
        end else if (key_ok) begin
            win_q <= 1'b1; // RQ25
            win_cnt_q <= 3'h0;
        end else if (prot_wr) begin
            win_q <= 1'b0; // RQ25
        end else if (win_q && sys_tick) begin
            win_cnt_q <= win_cnt_q + 3'h1;
            if (win_cnt_q == clk_ctrl_pkg::WIN_TICKS - 3'h1) begin
                win_q <= 1'b0; // RQ25
            end
        end
    end

    // Protected and plain configuration registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_q <= clk_ctrl_pkg::SRC_RST;
            div_q <= clk_ctrl_pkg::DIV_RST; // RQ9
            arm_q <= 1'b0;
            kind_q <= clk_ctrl_pkg::KIND_IDLE;
        end else begin
            if (sel_upd) begin
                sel_q <= wd_src;
            end
            if (div_upd) begin
                div_q <= wd_div;
            end
            if (wr_pwr) begin
                arm_q <= hwdata[clk_ctrl_pkg::PWR_ARM_BIT];
                kind_q <= hwdata[clk_ctrl_pkg::PWR_KIND_LSB +: clk_ctrl_pkg::KIND_W];
            end
        end
    end

    // Trim: factory byte caught on first edge after reset release
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trim_q <= clk_ctrl_pkg::TRIM_RST;
            trim_loaded_q <= 1'b0;
        end else if (!trim_loaded_q) begin
            trim_q <= factory_trim; // RQ11
            trim_loaded_q <= 1'b1;
        end else if (wr_trim) begin
            trim_q <= hwdata[7:0];
        end
    end
    assign osc_trim = trim_q; // RQ12

    // Source tick mux for requested and running source
    logic old_tick;
    logic new_tick;
    always_comb begin
        case (src_q)
            clk_ctrl_pkg::SRC_OSC8M: old_tick = osc8m_tick; // RQ2
            clk_ctrl_pkg::SRC_OSC128K: old_tick = osc128k_tick;
            clk_ctrl_pkg::SRC_EXT: old_tick = ext_clk_tick;
            default: old_tick = 1'b0;
        endcase
        case (sel_q)
            clk_ctrl_pkg::SRC_OSC8M: new_tick = osc8m_tick;
            clk_ctrl_pkg::SRC_OSC128K: new_tick = osc128k_tick;
            clk_ctrl_pkg::SRC_EXT: new_tick = ext_clk_tick;
            default: new_tick = 1'b0;
        endcase
    end

    // Glitch-free switch: finish old period, go quiet, start on new edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_q <= clk_ctrl_pkg::SRC_RST;
            switching_q <= 1'b0;
        end else if (switching_q) begin
            if (new_tick) begin
                src_q <= sel_q; // RQ3
                switching_q <= 1'b0;
            end
        end else if ((sel_q != src_q) && old_tick) begin
            switching_q <= 1'b1; // RQ3
        end
    end
    assign main_src_active = src_q;
    assign main_tick = old_tick && !switching_q && main_osc_en;

    // Prescaler drives the common system clock enable
    assign dif.main_tick = main_tick;
    assign dif.div_sel = div_q;
    assign sys_tick = dif.sys_tick; // RQ7

    // Wake qualification; deep modes take irq zero only in level mode, two-wire only on address match
    wire ext0_lvl = ext_irq_zero && ext_irq_zero_level_mode; // RQ16
    wire twi_am = two_wire_slave_irq && two_wire_slave_addr_match; // RQ16
    wire deep_wake = ext0_lvl || pin_change_irq || watchdog_osc_irq || twi_am;
    logic wake;
    always_comb begin
        case (cur_kind_q)
            clk_ctrl_pkg::KIND_IDLE: wake = irq_any; // RQ15
            clk_ctrl_pkg::KIND_NOISE: wake = deep_wake || converter_done_irq; // RQ15
            default: wake = deep_wake; // RQ15
        endcase
    end
    wire kind_ok = (kind_q == clk_ctrl_pkg::KIND_IDLE) || (kind_q == clk_ctrl_pkg::KIND_NOISE)
        || (kind_q == clk_ctrl_pkg::KIND_PDOWN) || (kind_q == clk_ctrl_pkg::KIND_STBY); // RQ21
    wire enter = sleep_instr && arm_q && kind_ok; // RQ13
    wire pd = cur_kind_q == clk_ctrl_pkg::KIND_PDOWN;
    wire cnt_done = cnt_q == clk_ctrl_pkg::HALT_TICKS - 3'h1;
    wire osc_done = cnt_q == clk_ctrl_pkg::OSC_START_TICKS - 3'h1;

    // Sleep sequencer; async reset drops straight back to run
    always_comb begin
        st_d = st_q;
        case (st_q)
            clk_ctrl_pkg::ST_RUN: if (enter) begin
                st_d = clk_ctrl_pkg::ST_SLEEP;
            end
            clk_ctrl_pkg::ST_SLEEP: if (wake) begin
                st_d = pd ? clk_ctrl_pkg::ST_OSC_START : clk_ctrl_pkg::ST_HALT; // RQ23
            end
            clk_ctrl_pkg::ST_OSC_START: if (main_tick && osc_done) begin
                st_d = clk_ctrl_pkg::ST_HALT; // RQ23
            end
            clk_ctrl_pkg::ST_HALT: if (sys_tick && cnt_done) begin
                st_d = clk_ctrl_pkg::ST_RUN; // RQ17
            end
            default: st_d = clk_ctrl_pkg::ST_RUN;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= clk_ctrl_pkg::ST_RUN; // RQ19
            cur_kind_q <= clk_ctrl_pkg::KIND_IDLE;
        end else begin
            st_q <= st_d;
            if (enter && st_q == clk_ctrl_pkg::ST_RUN) begin
                cur_kind_q <= kind_q;
            end
        end
    end

    // Shared counter for oscillator start-up and halt cycles
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 3'h0;
        end else if (st_q != st_d) begin
            cnt_q <= 3'h0;
        end else if ((st_q == clk_ctrl_pkg::ST_OSC_START && main_tick)
                || (st_q == clk_ctrl_pkg::ST_HALT && sys_tick)) begin
            cnt_q <= cnt_q + 3'h1;
        end
    end

    // Domain enables; state elsewhere is untouched across sleep
    wire in_sleep = st_q == clk_ctrl_pkg::ST_SLEEP;
    wire k_idle = cur_kind_q == clk_ctrl_pkg::KIND_IDLE;
    wire k_noise = cur_kind_q == clk_ctrl_pkg::KIND_NOISE;
    assign core_clk_domain_en = sys_tick && !sleeping; // RQ14 RQ18
    assign nvmem_clk_domain_en = sys_tick && !sleeping; // RQ14
    assign periph_clk_domain_en = sys_tick && (!in_sleep || k_idle); // RQ14
    assign converter_clk_domain_en = sys_tick && (!in_sleep || k_idle || k_noise); // RQ14
    assign main_osc_en = !(in_sleep && pd); // RQ14
    assign core_halted = sleeping;
    assign irq_service = (st_q == clk_ctrl_pkg::ST_HALT) && sys_tick && cnt_done; // RQ17

    // Checks
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_rsv_sel;
        rd_wait_q && addr_q == clk_ctrl_pkg::OFS_MAIN_SEL |=> hrdata[31:2] == 30'h0;
    endproperty
    a_rsv_sel: assert property (p_rsv_sel) else $error("select reserved bits set"); // RQ1
    property p_rsv_div;
        rd_wait_q && addr_q == clk_ctrl_pkg::OFS_DIV |=> hrdata[31:4] == 28'h0;
    endproperty
    a_rsv_div: assert property (p_rsv_div) else $error("divider reserved bits set"); // RQ5
    property p_locked;
        wr_pend_q && !win_q |=> $stable(sel_q) && $stable(div_q);
    endproperty
    a_locked: assert property (p_locked) else $error("unprotected clock change"); // RQ4
    property p_div_legal;
        div_q <= clk_ctrl_pkg::DIV_MAX && sel_q != clk_ctrl_pkg::SRC_RSVD;
    endproperty
    a_div_legal: assert property (p_div_legal) else $error("reserved code stored"); // RQ24
    property p_win_len;
        win_q |-> win_cnt_q < clk_ctrl_pkg::WIN_TICKS;
    endproperty
    a_win_len: assert property (p_win_len) else $error("window too long"); // RQ25
    property p_switch;
        !switching_q && !$past(switching_q) |-> $stable(src_q);
    endproperty
    a_switch: assert property (p_switch) else $error("source switched without gap"); // RQ3
    property p_pd_gate;
        in_sleep && pd |-> !main_osc_en && !periph_clk_domain_en && !converter_clk_domain_en;
    endproperty
    a_pd_gate: assert property (p_pd_gate) else $error("power-down clock running"); // RQ14
    property p_core_stop;
        sleeping |-> !core_clk_domain_en && !nvmem_clk_domain_en;
    endproperty
    a_core_stop: assert property (p_core_stop) else $error("core clocked in sleep"); // RQ14
    property p_osc_exit;
        st_q == clk_ctrl_pkg::ST_OSC_START && st_d != st_q |-> osc_done && main_tick;
    endproperty
    a_osc_exit: assert property (p_osc_exit) else $error("start-up cut short"); // RQ23
    property p_service;
        irq_service |-> cnt_q == clk_ctrl_pkg::HALT_TICKS - 3'h1 ##1 st_q == clk_ctrl_pkg::ST_RUN;
    endproperty
    a_service: assert property (p_service) else $error("halt length wrong"); // RQ17
    property p_entry;
        st_q == clk_ctrl_pkg::ST_RUN ##1 st_q == clk_ctrl_pkg::ST_SLEEP |-> $past(arm_q);
    endproperty
    a_entry: assert property (p_entry) else $error("sleep without arm"); // RQ13
    c_sleep: cover property (st_q == clk_ctrl_pkg::ST_SLEEP);
    c_pd_wake: cover property (st_q == clk_ctrl_pkg::ST_OSC_START ##1 st_q == clk_ctrl_pkg::ST_HALT);
    c_prot: cover property (sel_upd || div_upd);
    c_switch: cover property ($fell(switching_q));
endmodule

// ==== src/clk_ctrl_pkg.sv ====
// Shared constants for clock select, prescaler and sleep control
package clk_ctrl_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_MAIN_SEL = 8'h00;
    localparam logic [7:0] OFS_DIV = 8'h04;
    localparam logic [7:0] OFS_TRIM = 8'h08;
    localparam logic [7:0] OFS_KEY = 8'h0C;
    localparam logic [7:0] OFS_PWR = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h14;
    // Field widths and positions
    localparam int SRC_W = 2;
    localparam int DIV_W = 4;
    localparam int KIND_W = 3;
    localparam int CNT_W = 8;
    localparam int PWR_ARM_BIT = 0;
    localparam int PWR_KIND_LSB = 1;
    localparam int STAT_DIV_LSB = 2;
    localparam int STAT_SLEEP_BIT = 6;
    localparam int STAT_WIN_BIT = 7;
    // Reset values and divider limit
    localparam logic [SRC_W-1:0] SRC_RST = 2'h0;
    localparam logic [DIV_W-1:0] DIV_RST = 4'h3;
    localparam logic [7:0] TRIM_RST = 8'h00;
    localparam logic [DIV_W-1:0] DIV_MAX = 4'h8;
    // Source codes
    localparam logic [SRC_W-1:0] SRC_OSC8M = 2'h0;
    localparam logic [SRC_W-1:0] SRC_OSC128K = 2'h1;
    localparam logic [SRC_W-1:0] SRC_EXT = 2'h2;
    localparam logic [SRC_W-1:0] SRC_RSVD = 2'h3;
    // Sleep kind codes
    localparam logic [KIND_W-1:0] KIND_IDLE = 3'h0;
    localparam logic [KIND_W-1:0] KIND_NOISE = 3'h1;
    localparam logic [KIND_W-1:0] KIND_PDOWN = 3'h2;
    localparam logic [KIND_W-1:0] KIND_STBY = 3'h4;
    // Unlock signature, value is arbitrary
    localparam logic [7:0] UNLOCK_KEY = 8'hA5;
    // Cycle counts
    localparam logic [2:0] WIN_TICKS = 3'h4;
    localparam logic [2:0] OSC_START_TICKS = 3'h6;
    localparam logic [2:0] HALT_TICKS = 3'h4;
    // AHB encodings and sleep sequencer states
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;
    typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_OSC_START, ST_HALT} sleep_state_type;
endpackage

// ==== src/sys_div_if.sv ====
// Link between the control block and the system clock prescaler
`timescale 1ns/10ps
interface sys_div_if;
    logic main_tick;
    logic [clk_ctrl_pkg::DIV_W-1:0] div_sel;
    logic sys_tick;
    logic [clk_ctrl_pkg::DIV_W-1:0] div_active;
    modport ctrl (output main_tick, output div_sel, input sys_tick, input div_active);
    modport div (input main_tick, input div_sel, output sys_tick, output div_active);
endinterface

// ==== src/sys_prescaler.sv ====
// Power-of-two system clock enable divider with boundary-only updates
`timescale 1ns/10ps
module sys_prescaler (
    input wire logic hclk,
    input wire logic hresetn,
    sys_div_if.div dif
);
    logic [clk_ctrl_pkg::CNT_W-1:0] cnt_q;
    logic [clk_ctrl_pkg::CNT_W-1:0] cnt_d;
    logic [clk_ctrl_pkg::DIV_W-1:0] act_q;
    logic [clk_ctrl_pkg::CNT_W-1:0] limit;
    logic wrap;

    // Terminal count is two to the power of the active setting, minus one
    assign limit = clk_ctrl_pkg::CNT_W'((9'h001 << act_q) - 9'h001); // RQ6
    assign wrap = dif.main_tick && (cnt_q == limit);
    assign cnt_d = wrap ? '0 : cnt_q + clk_ctrl_pkg::CNT_W'(1);
    assign dif.sys_tick = wrap;
    assign dif.div_active = act_q;

    // New setting taken only at a period boundary so no short period appears
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= '0;
            act_q <= clk_ctrl_pkg::DIV_RST;
        end else if (dif.main_tick) begin
            cnt_q <= cnt_d;
            if (wrap) begin
                act_q <= dif.div_sel; // RQ22
            end
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_div_boundary;
        !wrap |=> $stable(act_q);
    endproperty
    a_div_boundary: assert property (p_div_boundary) else $error("divider changed mid period"); // RQ22
    property p_div_count;
        wrap |-> cnt_q == limit;
    endproperty
    a_div_count: assert property (p_div_count) else $error("sys tick off count"); // RQ6
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench for clock select, prescaler, trim and sleep control
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic hsel = 1'h0;
    logic hwrite = 1'h0;
    logic sleep_instr = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [7:0] wk = 8'h0;
    logic [3:0] tcnt = 4'h0;
    logic [31:0] r;
    int n_errors = 0;
    int n_checks = 0;
    wire hready, hreadyout, hresp, main_tick, sys_tick, core_en, nvm_en, per_en, conv_en;
    wire main_osc_en, core_halted, irq_service;
    wire [31:0] hrdata;
    wire [7:0] osc_trim;
    wire [1:0] main_src_active;
    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;
    always #4 hclk = ~hclk;
    // Source ticks: 8M every 4, external every 8, 128k every 16 cycles
    always @(posedge hclk) tcnt <= tcnt + 4'h1;
    clock_select_prescale_sleep dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .osc8m_tick(tcnt[1:0] == 2'h0), .osc128k_tick(tcnt == 4'h0),
        .ext_clk_tick(tcnt[2:0] == 3'h0), .factory_trim(8'h5C), .osc_trim(osc_trim),
        .main_src_active(main_src_active), .main_tick(main_tick), .sys_tick(sys_tick),
        .sleep_instr(sleep_instr), .irq_any(wk[0]), .ext_irq_zero(wk[1]),
        .ext_irq_zero_level_mode(wk[7]), .pin_change_irq(wk[2]), .watchdog_osc_irq(wk[3]),
        .two_wire_slave_irq(wk[4]), .two_wire_slave_addr_match(wk[5]),
        .converter_done_irq(wk[6]), .core_clk_domain_en(core_en), .nvmem_clk_domain_en(nvm_en),
        .periph_clk_domain_en(per_en), .converter_clk_domain_en(conv_en),
        .main_osc_en(main_osc_en), .core_halted(core_halted), .irq_service(irq_service));
    // One AHB single transfer; entered just after a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'h1;
        haddr <= {24'h0, a};
        htrans <= clk_ctrl_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'h1);
        r = hrdata;
    endtask
    task automatic key_wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'h1, clk_ctrl_pkg::OFS_KEY, {24'h0, clk_ctrl_pkg::UNLOCK_KEY});
        bus(1'h1, a, d);
    endtask
    task automatic wait_sys(input int n);
        repeat (n) do @(posedge hclk); while (sys_tick !== 1'h1);
    endtask
    // Cycles between two consecutive main ticks
    task automatic gap(output int g);
        do @(posedge hclk); while (main_tick !== 1'h1);
        g = 0;
        do begin @(posedge hclk); g++; end while (main_tick !== 1'h1 && g < 100);
    endtask
    task automatic t_reset;
        bus(1'h0, clk_ctrl_pkg::OFS_MAIN_SEL, 32'h0); `CHK("sel", 32'h0, r)
        bus(1'h0, clk_ctrl_pkg::OFS_DIV, 32'h0); `CHK("div", 32'h3, r)
        bus(1'h0, clk_ctrl_pkg::OFS_TRIM, 32'h0); `CHK("trim", 32'h5C, r)
        `CHK("trim_out", 8'h5C, osc_trim)
        bus(1'h0, 8'h40, 32'h0); `CHK("unmapped", 32'h0, r)
        bus(1'h0, clk_ctrl_pkg::OFS_STAT, 32'h0); `CHK("stat", 32'h0000_000C, r)
        bus(1'h1, clk_ctrl_pkg::OFS_TRIM, 32'hFFFF_FF00);
        bus(1'h0, clk_ctrl_pkg::OFS_TRIM, 32'h0); `CHK("trim0", 32'h0, r)
        bus(1'h1, clk_ctrl_pkg::OFS_TRIM, 32'h0000_00FF);
        @(posedge hclk);
        `CHK("trim_ff", 8'hFF, osc_trim)
        `CHK("hresp", clk_ctrl_pkg::HRESP_OKAY, hresp)
    endtask
    // Unprotected, reserved and late divider writes and a reserved select write all leave the protected divider and select registers alone
    task automatic t_protect;
        bus(1'h1, clk_ctrl_pkg::OFS_DIV, 32'h1);
        bus(1'h0, clk_ctrl_pkg::OFS_DIV, 32'h0); `CHK("div_nokey", 32'h3, r)
        key_wr(clk_ctrl_pkg::OFS_DIV, 32'hFFFF_FFF9);
        bus(1'h1, clk_ctrl_pkg::OFS_DIV, 32'h1);
        bus(1'h0, clk_ctrl_pkg::OFS_DIV, 32'h0); `CHK("div_rsvd", 32'h3, r)
        bus(1'h1, clk_ctrl_pkg::OFS_KEY, {24'h0, clk_ctrl_pkg::UNLOCK_KEY});
        wait_sys(5);
        bus(1'h1, clk_ctrl_pkg::OFS_DIV, 32'h1);
        bus(1'h0, clk_ctrl_pkg::OFS_DIV, 32'h0); `CHK("div_late", 32'h3, r)
        key_wr(clk_ctrl_pkg::OFS_MAIN_SEL, 32'h3);
        bus(1'h0, clk_ctrl_pkg::OFS_MAIN_SEL, 32'h0); `CHK("sel_rsvd", 32'h0, r)
    endtask
    // Each source in turn; no tick may come faster than the fastest source
    task automatic t_src;
        logic [1:0] src [3] = '{2'h1, 2'h2, 2'h0};
        int per [3] = '{16, 8, 4};
        int g;
        for (int i = 0; i < 3; i++) begin
            key_wr(clk_ctrl_pkg::OFS_MAIN_SEL, {30'h3FFF_FFFF, src[i]});
            bus(1'h0, clk_ctrl_pkg::OFS_MAIN_SEL, 32'h0); `CHK("sel_rd", {30'h0, src[i]}, r)
            for (int k = 0; k < 6; k++) begin
                gap(g);
                `CHK("no_runt", 1'h1, g >= 4)
            end
            `CHK("src_active", src[i], main_src_active)
            gap(g); `CHK("src_period", per[i], g)
        end
    endtask
    // Main ticks per system tick equal two to the field
    task automatic t_div;
        int n;
        for (int d = 0; d <= 8; d++) begin
            key_wr(clk_ctrl_pkg::OFS_DIV, d);
            bus(1'h0, clk_ctrl_pkg::OFS_DIV, 32'h0); `CHK("div_rd", d, r)
            wait_sys(2);
            n = 0;
            do begin @(posedge hclk); n += main_tick; end while (sys_tick !== 1'h1);
            `CHK("div_ratio", 1 << d, n)
        end
        key_wr(clk_ctrl_pkg::OFS_DIV, 32'h3);
        wait_sys(2);
    endtask
    task automatic pulse_sleep(input logic [3:0] pw);
        bus(1'h1, clk_ctrl_pkg::OFS_PWR, {28'h0, pw});
        sleep_instr <= 1'h1;
        @(posedge hclk);
        sleep_instr <= 1'h0;
        @(posedge hclk);
        @(posedge hclk);
    endtask
    // Without the arm bit, or with an unassigned kind, the core keeps running
    task automatic t_arm;
        pulse_sleep(4'h0); `CHK("no_arm", 1'h0, core_halted)
        pulse_sleep(4'h7); `CHK("bad_kind", 1'h0, core_halted)
        bus(1'h0, clk_ctrl_pkg::OFS_PWR, 32'h0); `CHK("pwr_rd", 32'h7, r)
    endtask
    // Gating per kind; a wrong source must not wake, the right one must
    task automatic sleep_case(input logic [2:0] kind, input logic per, input logic cnv,
                              input logic osc, input logic [7:0] bad, input logic [7:0] good);
        int cp;
        int pp;
        int vp;
        int ns;
        int k;
        cp = 0; pp = 0; vp = 0; ns = 0; k = 0;
        pulse_sleep({kind, 1'h1});
        wk <= bad;
        repeat (150) begin
            @(posedge hclk);
            cp += core_en + nvm_en;
            pp += per_en;
            vp += conv_en;
        end
        `CHK("core_gated", 0, cp)
        `CHK("periph_run", per, pp > 0)
        `CHK("conv_run", cnv, vp > 0)
        `CHK("osc_run", osc, main_osc_en)
        `CHK("still_asleep", 1'h1, core_halted)
        wk <= good;
        @(posedge hclk);
        do begin @(posedge hclk); k++; ns += sys_tick; end
        while (irq_service !== 1'h1 && k < 3000);
        `CHK("serviced", 1'h1, irq_service)
        if (kind != clk_ctrl_pkg::KIND_PDOWN) `CHK("halt_ticks", 4, ns)
        wk <= 8'h0;
        @(posedge hclk);
        `CHK("resumed", 1'h0, core_halted)
        `CHK("osc_back", 1'h1, main_osc_en)
    endtask
    // A reset during sleep brings back run state and reset values
    task automatic t_rst_sleep;
        pulse_sleep({clk_ctrl_pkg::KIND_IDLE, 1'h1}); `CHK("slept", 1'h1, core_halted)
        hresetn <= 1'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        `CHK("rst_wake", 1'h0, core_halted)
        bus(1'h0, clk_ctrl_pkg::OFS_DIV, 32'h0); `CHK("rst_div", 32'h3, r)
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Whole run needs well under this span
    initial begin
        #(8 * 60000);
        n_errors++;
        tally_and_finish;
    end
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        t_reset;
        t_protect;
        t_src;
        t_div;
        t_arm;
        sleep_case(clk_ctrl_pkg::KIND_IDLE, 1'h1, 1'h1, 1'h1, 8'h00, 8'h01);
        sleep_case(clk_ctrl_pkg::KIND_NOISE, 1'h0, 1'h1, 1'h1, 8'h01, 8'h40);
        sleep_case(clk_ctrl_pkg::KIND_NOISE, 1'h0, 1'h1, 1'h1, 8'h00, 8'h04);
        sleep_case(clk_ctrl_pkg::KIND_STBY, 1'h0, 1'h0, 1'h1, 8'h50, 8'h30);
        sleep_case(clk_ctrl_pkg::KIND_PDOWN, 1'h0, 1'h0, 1'h0, 8'h02, 8'h82);
        sleep_case(clk_ctrl_pkg::KIND_PDOWN, 1'h0, 1'h0, 1'h0, 8'h41, 8'h08);
        t_rst_sleep;
        tally_and_finish;
    end
endmodule
